// [sim/mux_bus_host_port_sva.sv]
`timescale 1ns/1ns
// ==================================================================
// Bus protocol checks, device side of the shared lines
module mux_bus_host_port_sva (
    input logic       sys_clk,
    input logic       rst_b,
    input logic [7:0] mux_bus_line,
    input logic       addr_latch,
    input logic       chip_sel,
    input logic       read_cmd_n,
    input logic       write_cmd_n,
    input logic [7:0] dev_bus_out,
    input logic       dev_bus_oe,
    input logic       int_dev_oe
);
    logic       ale_prev_reg;
    logic       acc_prev_reg;
    logic [7:0] addr_reg;
    logic       rd_cond;
    logic       acc_now;

    // Decoded access conditions
    assign rd_cond = chip_sel && !read_cmd_n && write_cmd_n;
    assign acc_now = chip_sel && !(read_cmd_n && write_cmd_n);

    // Address captured on strobe fall
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ale_prev_reg <= 1'b0;
            addr_reg     <= 8'h00;
        end else begin
            ale_prev_reg <= addr_latch;
            if (ale_prev_reg && !addr_latch) begin
                addr_reg <= mux_bus_line;
            end
        end
    end

    // Previous access level for start detection
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            acc_prev_reg <= 1'b0;
        end else begin
            acc_prev_reg <= acc_now;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    // ==============================================================
    // Sequences and properties
    sequence s_read;
        rd_cond;
    endsequence
    sequence s_read_held;
        rd_cond [*3];
    endsequence
    sequence s_int_start;
        acc_now && !acc_prev_reg && addr_reg >= mux_bus_pkg::INT_FIRST_ADDR
            && addr_reg <= mux_bus_pkg::INT_LAST_ADDR;
    endsequence

    property p_oe_cause;   dev_bus_oe |-> $past(rd_cond);                        endproperty
    property p_read_ans;   s_read |=> dev_bus_oe;                                endproperty
    property p_read_drop;  $fell(rd_cond) |=> !dev_bus_oe;                       endproperty
    property p_cs_low;     !chip_sel |=> !dev_bus_oe;                            endproperty
    property p_both_high;  chip_sel && read_cmd_n && write_cmd_n |=> !dev_bus_oe; endproperty
    property p_strobe_wr;  chip_sel && !read_cmd_n && !write_cmd_n |=> !dev_bus_oe;
    endproperty
    property p_read_stable; s_read_held |-> $stable(dev_bus_out);                endproperty
    property p_int_release; s_int_start |=> !int_dev_oe;                         endproperty
    property p_reset_quiet; $rose(rst_b) |-> (!dev_bus_oe && !int_dev_oe) [*8]; endproperty

    a_oe_cause:    assert property (p_oe_cause)    else $error("bus driven without read");
    a_read_ans:    assert property (p_read_ans)    else $error("read not answered");
    a_read_drop:   assert property (p_read_drop)   else $error("bus held after read");
    a_cs_low:      assert property (p_cs_low)      else $error("access with select low");
    a_both_high:   assert property (p_both_high)   else $error("idle commands acted on");
    a_strobe_wr:   assert property (p_strobe_wr)   else $error("strobe write drove bus");
    a_read_stable: assert property (p_read_stable) else $error("read data moved");
    a_int_release: assert property (p_int_release) else $error("interrupt not released");
    a_reset_quiet: assert property (p_reset_quiet) else $error("active after reset");
endmodule

// [sim/mux_bus_host_port_test.sv]
`timescale 1ns/1ns
// ==================================================================
// Both bus ends joined, checked against a byte-map model
module mux_bus_host_port_test;
    logic       sys_clk;
    logic       rst_b;
    logic [5:0] int_event;
    logic       buffered_clock_out;
    logic       core_reset_active;
    logic       req_valid;
    logic       req_write;
    logic [7:0] req_addr;
    logic [7:0] req_wdata;
    logic       strobe_mode;
    logic       req_ready;
    logic       rsp_valid;
    logic [7:0] rsp_rdata;
    logic       irq_pending;
    logic       b0;
    int         fails;
    int         cmp_count;
    int         seed;
    int         mem [256];
    int         status;
    int         a;

    mux_bus_if mux_bus_if_i ();
    mux_bus_device mux_bus_device_i (.bus(mux_bus_if_i.device_mp), .sys_clk(sys_clk),
        .rst_b(rst_b), .int_event(int_event), .buffered_clock_out(buffered_clock_out),
        .core_reset_active(core_reset_active));
    mux_bus_host mux_bus_host_i (.bus(mux_bus_if_i.host_mp), .sys_clk(sys_clk), .rst_b(rst_b),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .strobe_mode(strobe_mode), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .irq_pending(irq_pending));
    mux_bus_host_port_sva mux_bus_sva_i (.sys_clk(sys_clk), .rst_b(rst_b),
        .mux_bus_line(mux_bus_if_i.mux_bus_line), .addr_latch(mux_bus_if_i.addr_latch),
        .chip_sel(mux_bus_if_i.chip_sel), .read_cmd_n(mux_bus_if_i.read_cmd_n),
        .write_cmd_n(mux_bus_if_i.write_cmd_n), .dev_bus_out(mux_bus_if_i.dev_bus_out),
        .dev_bus_oe(mux_bus_if_i.dev_bus_oe), .int_dev_oe(mux_bus_if_i.int_dev_oe));

    // Clock generator
    always #25 sys_clk = ~sys_clk;

    // ==============================================================
    // Tasks
    task automatic test_done();
        if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, seen);
            fails++;
        end
    endtask

    // One host transfer in a random bus style
    task automatic xfer(input logic w, input logic [7:0] ad, input logic [7:0] wd,
                        output logic [7:0] rv);
        int n;
        @(negedge sys_clk);
        req_valid   = 1'b1;
        req_write   = w;
        req_addr    = ad;
        req_wdata   = wd;
        strobe_mode = $random(seed);
        @(negedge sys_clk);
        req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        check("rsp_valid", {7'h0, rsp_valid}, 8'h01);
        rv = rsp_rdata;
        n = 0;
        while (req_ready !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        check("req_ready", {7'h0, req_ready}, 8'h01);
    endtask

    task automatic wr(input int ad, input int d);
        logic [7:0] rv;
        xfer(1'b1, ad[7:0], d[7:0], rv);
        if (ad != 3) mem[ad] = d & 8'hff;
    endtask

    task automatic rd_chk(input int ad);
        logic [7:0] rv;
        xfer(1'b0, ad[7:0], 8'h00, rv);
        check("read_data", rv, (ad == 9) ? status[7:0] : mem[ad][7:0]);
    endtask

    task automatic irq_chk(input logic exp);
        repeat (3) @(negedge sys_clk);
        check("irq_pending", {7'h0, irq_pending}, {7'h0, exp});
    endtask

    task automatic pulse(input int k);
        @(negedge sys_clk);
        int_event = 6'h01 << k;
        status    = status | (1 << k);
        @(negedge sys_clk);
        int_event = 6'h00;
    endtask

    // Wait for internal reset release, then look at clock output
    task automatic wait_core();
        int n;
        n = 0;
        while (core_reset_active !== 1'b0 && n < 40) begin
            @(negedge sys_clk);
            n++;
        end
        check("core_reset", {7'h0, core_reset_active}, 8'h00);
        check("settle_wait", {7'h0, n >= 8}, 8'h01);
        b0 = buffered_clock_out;
        @(negedge sys_clk);
        check("clock_out", {7'h0, buffered_clock_out}, {7'h0, ~b0});
        repeat (4) @(negedge sys_clk);
    endtask

    // Watchdog
    initial begin
        #2000000;
        fails++;
        test_done();
    end

    // ==============================================================
    // Main sequence
    initial begin
        sys_clk = 1'b0;
        rst_b = 1'b0;
        int_event = 6'h00;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 8'h00;
        req_wdata = 8'h00;
        strobe_mode = 1'b0;
        fails = 0;
        cmp_count = 0;
        seed = 32'h18d3;
        status = 0;
        foreach (mem[i]) mem[i] = 0;
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        check("clk_in_reset", {7'h0, buffered_clock_out}, 8'h00);
        check("core_in_reset", {7'h0, core_reset_active}, 8'h01);
        rst_b = 1'b1;
        wait_core();
        // Edge addresses then random traffic, interrupt block skipped
        foreach (mem[i]) if (i == 0 || i == 255 || i == 127 || i == 128) wr(i, 255 - i);
        rd_chk(255);
        rd_chk(0);
        rd_chk(128);
        rd_chk(127);
        for (int i = 0; i < 40; i++) begin
            a = $random(seed) & 8'hff;
            if (a == 3 || (a >= 8 && a <= 11)) a = a | 8'h10;
            if ($random(seed) & 1) wr(a, $random(seed));
            else rd_chk(a);
        end
        // Masked event, then enabled, then clears one by one
        wr(8, 8'h00);
        pulse(0);
        irq_chk(1'b0);
        rd_chk(9);
        wr(8, 8'h3f);
        irq_chk(1'b1);
        for (int k = 1; k < 6; k++) pulse(k);
        for (int k = 0; k < 6; k++) begin
            wr(10, 1 << k);
            status = status & ~(1 << k);
            rd_chk(9);
            irq_chk(status != 0);
        end
        // Soft reset clears the map
        wr(3, 8'h01);
        a = 0;
        while (core_reset_active !== 1'b1 && a < 10) begin
            @(negedge sys_clk);
            a++;
        end
        check("soft_reset", {7'h0, core_reset_active}, 8'h01);
        wait_core();
        foreach (mem[i]) mem[i] = 0;
        rd_chk(255);
        rd_chk(8);
        test_done();
    end
endmodule

// [verilog/mux_bus_device.sv]
`timescale 1ns/1ns
// What this block does
// - Latch address on address strobe falling edge
// - Registers and RAM as one 256-byte space
// - No access while chip select low
// - Strobe-mode write: select high, both commands low
// - Read: select high, read low, write high
// - Separate write: read high, write low
// - Processor may tie select high if alone
// - Strobe mode: read pin low, strobe toggles
// - Bus mode changes only with select inactive
// - Processor drives address then drops strobe
// - Then data or float, command with select
// - Processor ends access by terminating levels
// - Select may stay high through access
// - Decoder raises strobe only with processor strobe
// - One active-low open-drain interrupt output
// - Interrupt register access releases interrupt briefly
// - Release lasts one internal write strobe
// - Command register reset bit resets device
// - Pin and soft reset merged and shaped
// - Reset asserts at once, waits eight clocks
// - Reset released synchronously to clock
// - Clock output only driven outside reset; this block parks it low in reset
module mux_bus_device #(
    parameter int SRC_N = mux_bus_pkg::INT_SRC_N
) (
    mux_bus_if.device_mp     bus,
    input  logic             sys_clk,
    input  logic             rst_b,
    input  logic [SRC_N-1:0] int_event,
    output logic             buffered_clock_out,
    output logic             core_reset_active
);

    // ==============================================================
    // Declarations
    logic             core_rst_b;
    logic             soft_req_reg;
    logic             ale_prev_reg;
    logic [7:0]       addr_reg;
    logic             wr_prev_reg;
    logic             rd_prev_reg;
    logic             wr_cond;
    logic             rd_cond;
    logic             wr_start;
    logic             rd_start;
    logic             int_access;
    logic [7:0]       mem_reg [0:mux_bus_pkg::MEM_DEPTH-1];
    logic [SRC_N-1:0] status_reg;
    logic [SRC_N-1:0] clear_bits;
    logic             pending;
    logic [7:0]       release_reg;
    logic             int_oe_reg;
    logic [7:0]       bus_out_reg;
    logic             bus_oe_reg;
    logic             clk_out_reg;
    logic             reset_flag_reg;

    // ==============================================================
    // Helpers
    // True for addresses of the interrupt register group
    function automatic logic is_int_reg(input logic [7:0] a);
        is_int_reg = (a >= mux_bus_pkg::INT_FIRST_ADDR) &&
                     (a <= mux_bus_pkg::INT_LAST_ADDR);
    endfunction

    // Read value for an address
    function automatic logic [7:0] read_value(input logic [7:0] a);
        if (a == mux_bus_pkg::INT_STATUS_ADDR) begin
            read_value = {{(8 - SRC_N){1'b0}}, status_reg};
        end else begin
            read_value = mem_reg[a];
        end
    endfunction

    // ==============================================================
    // Reset generation
    reset_shaper u_reset (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .soft_req   (soft_req_reg),
        .core_rst_b (core_rst_b)
    );

    // ==============================================================
    // Address capture
    // Address taken on the cycle the strobe is first seen low
    always_ff @(posedge sys_clk or negedge core_rst_b) begin
        if (!core_rst_b) begin
            ale_prev_reg <= 1'b0;
            addr_reg     <= 8'h00;
        end else begin
            ale_prev_reg <= bus.addr_latch;
            if (ale_prev_reg && !bus.addr_latch) begin
                addr_reg <= bus.mux_bus_line;
            end
        end
    end

    // ==============================================================
    // Access decode
    // Write covers both modes: write pin low, read pin either level
    assign wr_cond    = bus.chip_sel && !bus.write_cmd_n;
    assign rd_cond    = bus.chip_sel && !bus.read_cmd_n &&
                        bus.write_cmd_n;
    assign wr_start   = wr_cond && !wr_prev_reg;
    assign rd_start   = rd_cond && !rd_prev_reg;
    assign int_access = (wr_start || rd_start) && is_int_reg(addr_reg);

    // Edge memory of the decoded commands
    always_ff @(posedge sys_clk or negedge core_rst_b) begin
        if (!core_rst_b) begin
            wr_prev_reg <= 1'b0;
            rd_prev_reg <= 1'b0;
        end else begin
            wr_prev_reg <= wr_cond;
            rd_prev_reg <= rd_cond;
        end
    end

    // ==============================================================
    // Register and RAM storage
    // One write per access; reset bit never stored
    always_ff @(posedge sys_clk or negedge core_rst_b) begin
        if (!core_rst_b) begin
            for (int i = 0; i < mux_bus_pkg::MEM_DEPTH; i++) begin
                mem_reg[i] <= mux_bus_pkg::MEM_RESET_VAL;
            end
        end else if (wr_start) begin
            mem_reg[addr_reg] <= bus.mux_bus_line;
            if (addr_reg == mux_bus_pkg::CMD_ADDR) begin
                mem_reg[addr_reg][mux_bus_pkg::SOFT_RESET_BIT] <= 1'b0;
            end
        end
    end

    // Soft reset request from the command register
    always_ff @(posedge sys_clk or negedge core_rst_b) begin
        if (!core_rst_b) begin
            soft_req_reg <= 1'b0;
        end else begin
            soft_req_reg <= wr_start && (addr_reg == mux_bus_pkg::CMD_ADDR) &&
                            bus.mux_bus_line[mux_bus_pkg::SOFT_RESET_BIT];
        end
    end

    // ==============================================================
    // Interrupt status and pin
    assign clear_bits = (wr_start && addr_reg == mux_bus_pkg::INT_CLEAR_ADDR) ?
                        bus.mux_bus_line[SRC_N-1:0] : '0;
    assign pending    = |(status_reg &
                          mem_reg[mux_bus_pkg::INT_ENABLE_ADDR][SRC_N-1:0]);

    // Sticky event bits, a new event beats its clear
    always_ff @(posedge sys_clk or negedge core_rst_b) begin
        if (!core_rst_b) begin
            status_reg <= '0;
        end else begin
            status_reg <= (status_reg & ~clear_bits) | int_event;
        end
    end

    // Release window counter
    always_ff @(posedge sys_clk or negedge core_rst_b) begin
        if (!core_rst_b) begin
            release_reg <= 8'h00;
        end else if (int_access) begin
            release_reg <= 8'(mux_bus_pkg::INT_RELEASE_CYC);
        end else if (release_reg != 8'h00) begin
            release_reg <= release_reg - 8'h01;
        end
    end

    // Open-drain pull-down, lifted during the release window
    always_ff @(posedge sys_clk or negedge core_rst_b) begin
        if (!core_rst_b) begin
            int_oe_reg <= 1'b0;
        end else begin
            int_oe_reg <= pending && !int_access &&
                          (release_reg <= 8'h01);
        end
    end

    // ==============================================================
    // Read data drive
    // Bus driven only in the cycle after each cycle a read is decoded
    always_ff @(posedge sys_clk or negedge core_rst_b) begin
        if (!core_rst_b) begin
            bus_oe_reg  <= 1'b0;
            bus_out_reg <= 8'h00;
        end else begin
            bus_oe_reg  <= rd_cond;
            bus_out_reg <= read_value(addr_reg);
        end
    end

    // ==============================================================
    // Clock out and reset indication
    // Half-rate clock out, parked low in reset
    always_ff @(posedge sys_clk or negedge core_rst_b) begin
        if (!core_rst_b) begin
            clk_out_reg <= 1'b0;
        end else begin
            clk_out_reg <= ~clk_out_reg;
        end
    end

    // Reset state flag
    always_ff @(posedge sys_clk or negedge core_rst_b) begin
        if (!core_rst_b) begin
            reset_flag_reg <= 1'b1;
        end else begin
            reset_flag_reg <= 1'b0;
        end
    end

    assign bus.dev_bus_out    = bus_out_reg;
    assign bus.dev_bus_oe     = bus_oe_reg;
    assign bus.int_dev_oe     = int_oe_reg;
    assign buffered_clock_out = clk_out_reg;
    assign core_reset_active  = reset_flag_reg;

endmodule

// [verilog/mux_bus_host.sv]
`timescale 1ns/1ns
// ==================================================================
// Processor-side sequencer for the multiplexed bus
module mux_bus_host #(
    parameter int CMD_CYC = mux_bus_pkg::HOST_CMD_CYC
) (
    mux_bus_if.host_mp  bus,
    input  logic        sys_clk,
    input  logic        rst_b,
    input  logic        req_valid,
    input  logic        req_write,
    input  logic [7:0]  req_addr,
    input  logic [7:0]  req_wdata,
    input  logic        strobe_mode,
    output logic        req_ready,
    output logic        rsp_valid,
    output logic [7:0]  rsp_rdata,
    output logic        irq_pending
);
    mux_bus_pkg::host_state_t state_reg;
    logic       write_reg;
    logic       mode_reg;
    logic [7:0] wdata_reg;
    logic [7:0] cnt_reg;
    logic [7:0] out_reg;
    logic       oe_reg;
    logic       ale_reg;
    logic       cs_reg;
    logic       rdn_reg;
    logic       wrn_reg;
    logic       ready_reg;
    logic       rsp_valid_reg;
    logic [7:0] rsp_reg;
    logic       irq_reg;

    // ==============================================================
    // Access sequence
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= mux_bus_pkg::H_IDLE;
            write_reg <= 1'b0;
            mode_reg  <= 1'b0;
            wdata_reg <= 8'h00;
            cnt_reg   <= 8'h00;
            out_reg   <= 8'h00;
            oe_reg    <= 1'b0;
            ale_reg   <= 1'b0;
            cs_reg    <= 1'b0;
            rdn_reg   <= 1'b1;
            wrn_reg   <= 1'b1;
            ready_reg <= 1'b1;
        end else begin
            case (state_reg)
                mux_bus_pkg::H_IDLE: begin
                    if (req_valid) begin
                        // Mode taken only while select is low
                        mode_reg  <= strobe_mode;
                        rdn_reg   <= ~strobe_mode;
                        write_reg <= req_write;
                        wdata_reg <= req_wdata;
                        out_reg   <= req_addr;
                        oe_reg    <= 1'b1;
                        ale_reg   <= 1'b1;
                        ready_reg <= 1'b0;
                        state_reg <= mux_bus_pkg::H_ADDR;
                    end
                end
                mux_bus_pkg::H_ADDR: begin
                    ale_reg   <= 1'b0;
                    state_reg <= mux_bus_pkg::H_LATCH;
                end
                mux_bus_pkg::H_LATCH: begin
                    out_reg   <= wdata_reg;
                    oe_reg    <= write_reg;
                    cs_reg    <= 1'b1;
                    wrn_reg   <= ~write_reg;
                    rdn_reg   <= mode_reg ? 1'b0 : write_reg;
                    cnt_reg   <= 8'(CMD_CYC - 1);
                    state_reg <= mux_bus_pkg::H_CMD;
                end
                mux_bus_pkg::H_CMD: begin
                    if (cnt_reg == 8'h00) begin
                        // Separate mode keeps select over idle commands
                        cs_reg    <= ~mode_reg;
                        wrn_reg   <= 1'b1;
                        rdn_reg   <= ~mode_reg;
                        oe_reg    <= 1'b0;
                        state_reg <= mux_bus_pkg::H_END;
                    end else begin
                        cnt_reg   <= cnt_reg - 8'h01;
                    end
                end
                mux_bus_pkg::H_END: begin
                    cs_reg    <= 1'b0;
                    ready_reg <= 1'b1;
                    state_reg <= mux_bus_pkg::H_IDLE;
                end
                default: begin
                    state_reg <= mux_bus_pkg::H_IDLE;
                end
            endcase
        end
    end

    // ==============================================================
    // Read answer capture
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rsp_valid_reg <= 1'b0;
            rsp_reg       <= 8'h00;
        end else begin
            rsp_valid_reg <= (state_reg == mux_bus_pkg::H_CMD) && (cnt_reg == 8'h00);
            if ((state_reg == mux_bus_pkg::H_CMD) && (cnt_reg == 8'h00) && !write_reg) begin
                rsp_reg <= bus.mux_bus_line;
            end
        end
    end

    // Interrupt line seen by the processor
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= ~bus.int_req_n;
        end
    end

    assign bus.host_bus_out = out_reg;
    assign bus.host_bus_oe  = oe_reg;
    assign bus.addr_latch   = ale_reg;
    assign bus.chip_sel     = cs_reg;
    assign bus.read_cmd_n   = rdn_reg;
    assign bus.write_cmd_n  = wrn_reg;
    assign req_ready        = ready_reg;
    assign rsp_valid        = rsp_valid_reg;
    assign rsp_rdata        = rsp_reg;
    assign irq_pending      = irq_reg;
endmodule

// [verilog/mux_bus_if.sv]
`timescale 1ns/1ns
// ==================================================================
// Shared multiplexed bus with wire resolution
interface mux_bus_if;
    logic [7:0] host_bus_out;
    logic       host_bus_oe;
    logic [7:0] dev_bus_out;
    logic       dev_bus_oe;
    logic [7:0] mux_bus_line;
    logic       addr_latch;
    logic       chip_sel;
    logic       read_cmd_n;
    logic       write_cmd_n;
    logic       int_dev_oe;
    logic       int_req_n;

    // Resolved levels, pull-ups when nobody drives
    assign mux_bus_line = dev_bus_oe  ? dev_bus_out  :
                          host_bus_oe ? host_bus_out : mux_bus_pkg::BUS_PULLUP;
    assign int_req_n    = ~int_dev_oe;

    modport device_mp (
        input  mux_bus_line,
        input  addr_latch,
        input  chip_sel,
        input  read_cmd_n,
        input  write_cmd_n,
        output dev_bus_out,
        output dev_bus_oe,
        output int_dev_oe
    );

    modport host_mp (
        input  mux_bus_line,
        input  int_req_n,
        output host_bus_out,
        output host_bus_oe,
        output addr_latch,
        output chip_sel,
        output read_cmd_n,
        output write_cmd_n
    );
endinterface

// [verilog/mux_bus_pkg.sv]
// ==================================================================
// Shared constants of the multiplexed host port
package mux_bus_pkg;

    // ==============================================================
    // Bus shape
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    localparam int          MEM_DEPTH       = 256;
    localparam int          INT_SRC_N       = 6;
    localparam logic [7:0]  BUS_PULLUP      = 8'hff;

    // ==============================================================
    // Register map
    localparam logic [7:0]  CMD_ADDR        = 8'h03;
    localparam int          SOFT_RESET_BIT  = 0;
    localparam logic [7:0]  INT_ENABLE_ADDR = 8'h08;
    localparam logic [7:0]  INT_STATUS_ADDR = 8'h09;
    localparam logic [7:0]  INT_CLEAR_ADDR  = 8'h0a;
    localparam logic [7:0]  INT_FIRST_ADDR  = 8'h08;
    localparam logic [7:0]  INT_LAST_ADDR   = 8'h0b;
    localparam logic [7:0]  MEM_RESET_VAL   = 8'h00;

    // ==============================================================
    // Timing
    localparam int          CLK_PERIOD_NS   = 50;
    localparam int          INT_RELEASE_NS  = 20;
    localparam int          INT_RELEASE_CYC = (INT_RELEASE_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                              (INT_RELEASE_NS / CLK_PERIOD_NS);
    localparam logic [3:0]  OSC_SETTLE_CYC  = 4'h8;
    localparam int          HOST_CMD_CYC    = 3;

    // ==============================================================
    // Host sequencer states
    typedef enum logic [2:0] {
        H_IDLE,
        H_ADDR,
        H_LATCH,
        H_CMD,
        H_END
    } host_state_t;

endpackage

// [verilog/reset_shaper.sv]
`timescale 1ns/1ns
// ==================================================================
// Merges pin and soft reset, releases after settle time
module reset_shaper (
    input  logic sys_clk,
    input  logic rst_b,
    input  logic soft_req,
    output logic core_rst_b
);
    logic [3:0] settle_reg;
    logic       core_rst_b_reg;

    // Pin reset asserts at once, soft request on a clock edge; release on a clock edge after settling
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            settle_reg     <= 4'h0;
            core_rst_b_reg <= 1'b0;
        end else if (soft_req) begin
            settle_reg     <= 4'h0;
            core_rst_b_reg <= 1'b0;
        end else if (settle_reg != mux_bus_pkg::OSC_SETTLE_CYC) begin
            settle_reg     <= settle_reg + 4'h1;
        end else begin
            core_rst_b_reg <= 1'b1;
        end
    end

    assign core_rst_b = core_rst_b_reg;
endmodule
